// *** serial_pkg.sv ***
package serial_pkg;
   // register offsets
   localparam logic [3:0] MLF_OFFSET      = 4'h5;
   localparam logic [3:0] RES_OFFSET      = 4'hA;
   localparam logic [3:0] FMT_OFFSET      = 4'h4;
   localparam logic [3:0] RESET_OFFSET    = 4'h0;
   localparam logic [3:0] DATA_OFFSET     = 4'h1;
   localparam logic [3:0] CTRL_OFFSET     = 4'h2;
   // modem line force fields
   localparam int MLF_DTR_BIT  = 0;
   localparam int MLF_RTS_BIT  = 1;
   localparam int MLF_DRS_BIT  = 2;
   localparam int MLF_SRTS_BIT = 3;
   // error status fields
   localparam int ERR_OVR_BIT = 1;
   localparam int ERR_PAR_BIT = 2;
   localparam int ERR_FRM_BIT = 3;
   localparam int ERR_BRK_BIT = 4;
   // format fields
   localparam int FMT_PEN_BIT  = 3;
   localparam int FMT_SENSE_LO = 4;
   localparam logic [1:0] SENSE_EVEN = 2'h1;
   // control fields
   localparam int CTRL_SIMPLE_BIT = 0;
   localparam int CTRL_RX_BIT     = 1;
   // reset values
   localparam logic [7:0] MLF_RST = 8'h00;
   localparam logic [7:0] FMT_RST = 8'h0B;
   localparam logic [7:0] CTL_RST = 8'h00;
   // timing
   localparam int CLK_HZ       = 200_000_000;
   localparam int BAUD         = 9600;
   localparam int BIT_CYCLES   = CLK_HZ / BAUD;
   localparam int HALF_CYCLES  = BIT_CYCLES / 2;
   localparam int FIFO_DEPTH   = 8;
   localparam int DATA_W       = 8;

   typedef struct packed {
      logic dtr;
      logic rts;
      logic drs;
      logic srts;
   } modem_out_t;

   typedef struct packed {
      logic dsr;
      logic cts;
      logic dcd;
   } modem_in_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } host_req_t;
endpackage : serial_pkg

// *** serial_fifo.sv ***
`timescale 1ns/100ps
module serial_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rp_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : serial_fifo

// *** serial_modem_handshake_error_status.sv ***
`timescale 1ns/100ps
// Overview of operation
// - receiver holds one character for host
// - transmit done only after last stop bit
// - transmit start drives dtr and rts active
// - transmit waits for dsr and cts active (dcd and cts in simple mode)
// - transmit end drops unforced dtr and rts
// - receive start drives dtr, rts stays low
// - receive accepts data only with dsr, dcd (dcd, cts in simple mode)
// - receive end drops unforced dtr
// - force bit 2 drives data rate select
// - force bit 3 drives secondary rts
// - force bits 1,0 hold rts, dtr active
// - simple mode: dtr follows carrier detect
// - parity mismatch sets error bit 2
// - bad stop bit sets error bit 3
// - lost character sets error bit 1
// - break sets bits 4 and 3
// - only received data raises error flags
// - any error raises pending status error
// - status read returns then clears bits 1-4
// - parity checked only when enabled, sense odd/even
// - interface reset clears modem force register
module serial_modem_handshake_error_status #(
   parameter int BIT_CYCLES = serial_pkg::BIT_CYCLES
) (
   input  wire logic       I_CLK_SYS,
   input  wire logic       I_RST_N,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic [3:0] i_addr,
   input  wire logic [7:0] i_wdata,
   output logic [7:0]      o_rdata,
   output logic            o_rvalid,
   output logic            o_tx_busy,
   output logic            o_tx_done,
   output logic            o_rx_full,
   output logic            o_err_pending,
   input  wire logic       i_rxd,
   input  wire logic       i_dsr,
   input  wire logic       i_cts,
   input  wire logic       i_dcd,
   output logic            o_txd,
   output logic            o_dtr,
   output logic            o_rts,
   output logic            o_drs,
   output logic            o_srts
);
   // ****************************************************************
   // host access and registers
   // ****************************************************************
   typedef enum {TX_IDLE, TX_WAIT, TX_SEND} tx_state_t;

   serial_pkg::host_req_t req;
   assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

   logic [7:0] mlf_r;
   logic [7:0] fmt_r;
   logic [7:0] ctl_r;
   logic [4:1] err_r;
   logic [7:0] rbuf_r;
   logic       rfull_r;
   logic       wr_mlf;
   logic       wr_rst;
   logic       rd_err;
   logic       rd_dat;

   assign wr_mlf = req.wr && (req.addr == serial_pkg::MLF_OFFSET);
   assign wr_rst = req.wr && (req.addr == serial_pkg::RESET_OFFSET) && (req.wdata != 8'h00);
   assign rd_err = req.rd && (req.addr == serial_pkg::RES_OFFSET);
   assign rd_dat = req.rd && (req.addr == serial_pkg::DATA_OFFSET);

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         mlf_r <= serial_pkg::MLF_RST;
      end else if (wr_rst) begin
         mlf_r <= serial_pkg::MLF_RST;
      end else if (wr_mlf) begin
         mlf_r <= req.wdata;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         fmt_r <= serial_pkg::FMT_RST;
         ctl_r <= serial_pkg::CTL_RST;
      end else if (req.wr && req.addr == serial_pkg::FMT_OFFSET) begin
         fmt_r <= req.wdata;
      end else if (req.wr && req.addr == serial_pkg::CTRL_OFFSET) begin
         ctl_r <= req.wdata;
      end else if (wr_rst) begin
         ctl_r <= serial_pkg::CTL_RST;
      end
   end

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   logic [3:0] s1_r;
   logic [3:0] s2_r;
   logic [3:0] s3_r;
   logic [3:0] stab_r;

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         s1_r   <= 4'hF;
         s2_r   <= 4'hF;
         s3_r   <= 4'hF;
         stab_r <= 4'h1;
      end else begin
         s1_r <= {i_dcd, i_cts, i_dsr, i_rxd};
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int k = 0; k < 4; k++) begin
            if (s2_r[k] == s3_r[k]) begin
               stab_r[k] <= s3_r[k];
            end
         end
      end
   end

   logic rxd;
   serial_pkg::modem_in_t mi;
   assign rxd = stab_r[0];
   assign mi  = '{dsr: stab_r[1], cts: stab_r[2], dcd: stab_r[3]};

   // ****************************************************************
   // transmit path: fifo then shifter
   // ****************************************************************
   logic       f_in_ready;
   logic       f_out_valid;
   logic       f_out_ready;
   logic [7:0] f_out_data;

   serial_fifo #(
      .WIDTH (serial_pkg::DATA_W),
      .DEPTH (serial_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (I_CLK_SYS),
      .rst_n     (I_RST_N),
      .in_valid  (req.wr && req.addr == serial_pkg::DATA_OFFSET),
      .in_ready  (f_in_ready),
      .in_data   (req.wdata),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   tx_state_t  tx_st_r;
   logic [9:0] tx_sh_r;
   logic [3:0] tx_bits_r;
   logic [15:0] tx_cnt_r;
   logic       tx_ok;
   logic       simple;

   assign simple = ctl_r[serial_pkg::CTRL_SIMPLE_BIT];
   assign tx_ok  = simple ? (mi.dcd && mi.cts) : (mi.dsr && mi.cts);
   assign f_out_ready = (tx_st_r == TX_WAIT) && tx_ok;

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         tx_st_r   <= TX_IDLE;
         tx_sh_r   <= 10'h3FF;
         tx_bits_r <= 4'h0;
         tx_cnt_r  <= 16'h0000;
         o_tx_done <= 1'b0;
      end else begin
         o_tx_done <= 1'b0;
         unique case (tx_st_r)
            TX_IDLE: begin
               if (f_out_valid) begin
                  tx_st_r <= TX_WAIT;
               end
            end
            TX_WAIT: begin
               if (!f_out_valid) begin
                  tx_st_r   <= TX_IDLE;
                  o_tx_done <= 1'b1;
               end else if (tx_ok) begin
                  tx_sh_r   <= {1'b1, f_out_data, 1'b0};
                  tx_bits_r <= 4'hA;
                  tx_cnt_r  <= 16'(BIT_CYCLES - 1);
                  tx_st_r   <= TX_SEND;
               end
            end
            TX_SEND: begin
               if (tx_cnt_r != 16'h0000) begin
                  tx_cnt_r <= tx_cnt_r - 16'h0001;
               end else if (tx_bits_r == 4'h1) begin
                  // stop bit fully out; next byte or finish
                  tx_sh_r <= 10'h3FF;
                  tx_st_r <= TX_WAIT;
               end else begin
                  tx_sh_r   <= {1'b1, tx_sh_r[9:1]};
                  tx_bits_r <= tx_bits_r - 4'h1;
                  tx_cnt_r  <= 16'(BIT_CYCLES - 1);
               end
            end
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         o_txd     <= 1'b1;
         o_tx_busy <= 1'b0;
      end else begin
         o_txd     <= (tx_st_r == TX_SEND) ? tx_sh_r[0] : 1'b1;
         o_tx_busy <= (tx_st_r != TX_IDLE) || f_out_valid;
      end
   end

   // ****************************************************************
   // receiver
   // ****************************************************************
   logic        rx_act_r;
   logic [15:0] rx_cnt_r;
   logic [3:0]  rx_idx_r;
   logic [8:0]  rx_sh_r;
   logic        rx_ok;
   logic        rx_en;
   logic        rx_end;
   logic        par_en;
   logic        par_bad;
   logic        frm_bad;
   logic        brk;
   logic [3:0]  last_idx;

   assign rx_en    = ctl_r[serial_pkg::CTRL_RX_BIT];
   assign rx_ok    = simple ? (mi.dcd && mi.cts) : (mi.dsr && mi.dcd);
   assign par_en   = fmt_r[serial_pkg::FMT_PEN_BIT];
   assign last_idx = par_en ? 4'hA : 4'h9;
   assign rx_end   = rx_act_r && (rx_cnt_r == 16'h0000) && (rx_idx_r == last_idx);

   // a break leaves the line low past its stop sample; only a fresh falling
   // edge may start a character, so the break tail cannot start a phantom one
   logic rxd_q_r;
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rxd_q_r <= 1'b1;
      end else begin
         rxd_q_r <= rxd;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rx_act_r <= 1'b0;
         rx_cnt_r <= 16'h0000;
         rx_idx_r <= 4'h0;
         rx_sh_r  <= 9'h000;
      end else if (!rx_act_r) begin
         if (rxd_q_r && !rxd && rx_en && rx_ok) begin
            rx_act_r <= 1'b1;
            rx_cnt_r <= 16'(BIT_CYCLES / 2);
            rx_idx_r <= 4'h0;
         end
      end else if (rx_cnt_r != 16'h0000) begin
         rx_cnt_r <= rx_cnt_r - 16'h0001;
      end else begin
         // sample mid-bit: 0 start, 1..8 data, optional parity, stop
         if (rx_idx_r != 4'h0 && rx_idx_r != last_idx) begin
            rx_sh_r <= {rxd, rx_sh_r[8:1]};
         end
         rx_cnt_r <= 16'(BIT_CYCLES - 1);
         rx_idx_r <= rx_idx_r + 4'h1;
         if (rx_end) begin
            rx_act_r <= 1'b0;
         end
      end
   end

   // odd parity means data plus parity has an odd count of ones
   always_comb begin
      logic [7:0] d;
      logic       p;
      d = par_en ? rx_sh_r[8:1] : rx_sh_r[8:1];
      p = 1'b0;
      if (par_en) begin
         d = rx_sh_r[7:0];
         p = rx_sh_r[8];
      end
      if (fmt_r[serial_pkg::FMT_SENSE_LO +: 2] == serial_pkg::SENSE_EVEN) begin
         par_bad = par_en && ((^d) != p);
      end else begin
         par_bad = par_en && ((^d) == p);
      end
   end

   assign frm_bad = !rxd;
   assign brk     = !rxd && (rx_sh_r == 9'h000);

   logic [7:0] rx_data;
   assign rx_data = par_en ? rx_sh_r[7:0] : rx_sh_r[8:1];

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rbuf_r  <= 8'h00;
         rfull_r <= 1'b0;
      end else if (rx_end && (!rfull_r || rd_dat)) begin
         // a read in the same cycle frees the buffer, so nothing is lost
         rbuf_r  <= rx_data;
         rfull_r <= 1'b1;
      end else if (rd_dat || wr_rst) begin
         rfull_r <= 1'b0;
      end
   end

   // ****************************************************************
   // error flags: set wins over the read clear
   // ****************************************************************
   logic [4:1] err_set;
   always_comb begin
      err_set = 4'h0;
      if (rx_end) begin
         err_set[serial_pkg::ERR_OVR_BIT] = rfull_r && !rd_dat;
         err_set[serial_pkg::ERR_PAR_BIT] = par_bad;
         err_set[serial_pkg::ERR_FRM_BIT] = frm_bad;
         err_set[serial_pkg::ERR_BRK_BIT] = brk;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         err_r <= 4'h0;
      end else if (rd_err || wr_rst) begin
         err_r <= err_set;
      end else begin
         err_r <= err_r | err_set;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         o_err_pending <= 1'b0;
      end else if (rd_err || wr_rst) begin
         o_err_pending <= |err_set;
      end else if (|err_set) begin
         o_err_pending <= 1'b1;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         o_rdata   <= 8'h00;
         o_rvalid  <= 1'b0;
         o_rx_full <= 1'b0;
      end else begin
         o_rvalid  <= req.rd;
         o_rx_full <= rfull_r;
         if (req.rd) begin
            unique case (req.addr)
               serial_pkg::RES_OFFSET:  o_rdata <= {3'h0, err_r, 1'b0};
               serial_pkg::MLF_OFFSET:  o_rdata <= mlf_r;
               serial_pkg::FMT_OFFSET:  o_rdata <= fmt_r;
               serial_pkg::CTRL_OFFSET: o_rdata <= ctl_r;
               serial_pkg::DATA_OFFSET: o_rdata <= rbuf_r;
               default:                 o_rdata <= {4'h0, mi.dcd, mi.cts, mi.dsr, f_in_ready};
            endcase
         end
      end
   end

   // ****************************************************************
   // modem line drivers
   // ****************************************************************
   logic tx_run;
   logic rx_run;
   assign tx_run = (tx_st_r != TX_IDLE);
   assign rx_run = rx_en;

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         o_dtr  <= 1'b0;
         o_rts  <= 1'b0;
         o_drs  <= 1'b0;
         o_srts <= 1'b0;
      end else begin
         o_drs  <= mlf_r[serial_pkg::MLF_DRS_BIT];
         o_srts <= mlf_r[serial_pkg::MLF_SRTS_BIT];
         if (simple) begin
            o_dtr <= mi.dcd || mlf_r[serial_pkg::MLF_DTR_BIT];
         end else begin
            o_dtr <= mlf_r[serial_pkg::MLF_DTR_BIT] || tx_run || rx_run;
         end
         o_rts <= mlf_r[serial_pkg::MLF_RTS_BIT] || tx_run;
      end
   end
endmodule : serial_modem_handshake_error_status

// *** serial_checker_props.sv ***
`timescale 1ns/100ps
// ************
// port checker
// ************
module serial_checker (
   input wire logic       I_CLK_SYS,
   input wire logic       I_RST_N,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   input wire logic       o_rvalid,
   input wire logic       o_tx_busy,
   input wire logic       o_tx_done,
   input wire logic       o_rx_full,
   input wire logic       o_err_pending,
   input wire logic       i_rxd,
   input wire logic       i_dsr,
   input wire logic       i_cts,
   input wire logic       i_dcd,
   input wire logic       o_txd,
   input wire logic       o_dtr,
   input wire logic       o_rts,
   input wire logic       o_drs,
   input wire logic       o_srts
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_N);
   sequence s_stat_rd;
      i_rd && i_addr == serial_pkg::RES_OFFSET ##1 o_rvalid;
   endsequence
   sequence s_mlf_wr;
      i_wr && i_addr == serial_pkg::MLF_OFFSET;
   endsequence
   a_read_answer: assert property (i_rd |=> o_rvalid) else $error("read not answered");
   a_unused_zero: assert property (s_stat_rd |-> o_rdata[0] == 1'b0 && o_rdata[7:5] == 3'h0)
      else $error("unused status bits set");
   a_done_pulse: assert property (o_tx_done |-> o_txd ##1 !o_tx_done)
      else $error("done not a pulse on idle line");
   a_idle_high: assert property (!o_tx_busy |-> o_txd) else $error("line low while idle");
   a_start_lines: assert property ($fell(o_txd) |-> o_dtr && o_rts)
      else $error("start bit without dtr and rts");
   a_drs_set: assert property ((s_mlf_wr and i_wdata[2]) |-> ##[1:2] o_drs)
      else $error("rate select not set");
   a_drs_clear: assert property ((s_mlf_wr and !i_wdata[2]) |-> ##[1:2] !o_drs)
      else $error("rate select not cleared");
   a_srts_set: assert property ((s_mlf_wr and i_wdata[3]) |-> ##[1:2] o_srts)
      else $error("secondary rts not set");
   a_force_rts: assert property ((s_mlf_wr and i_wdata[1]) |-> ##[1:2] o_rts)
      else $error("forced rts not active");
   a_force_dtr: assert property ((s_mlf_wr and i_wdata[0]) |-> ##[1:2] o_dtr)
      else $error("forced dtr not active");
   a_reset_clear: assert property (i_wr && i_addr == serial_pkg::RESET_OFFSET &&
      i_wdata != 8'h00 |-> ##[1:2] !o_drs && !o_srts) else $error("reset left lines forced");
endmodule : serial_checker

bind serial_modem_handshake_error_status serial_checker u_chk (
   .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
   .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_tx_busy(o_tx_busy),
   .o_tx_done(o_tx_done), .o_rx_full(o_rx_full), .o_err_pending(o_err_pending),
   .i_rxd(i_rxd), .i_dsr(i_dsr), .i_cts(i_cts), .i_dcd(i_dcd), .o_txd(o_txd),
   .o_dtr(o_dtr), .o_rts(o_rts), .o_drs(o_drs), .o_srts(o_srts));

// *** modem_peer.sv ***
`timescale 1ns/100ps
// **********
// modem side
// **********
module modem_peer #(
   parameter int BIT = serial_pkg::BIT_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       txd,
   output logic            rxd,
   output logic            dsr,
   output logic            cts,
   output logic            dcd,
   output logic [7:0]      got,
   output logic            got_v
);
   initial begin
      rxd = 1'b1;
      dsr = 1'b0;
      cts = 1'b0;
      dcd = 1'b0;
      got = 8'h00;
      got_v = 1'b0;
   end
   // holding cts low stalls the sender, so slow answers come for free
   task automatic lines(input logic d, input logic c, input logic k);
      @(posedge clk);
      dsr <= d;
      cts <= c;
      dcd <= k;
   endtask : lines
   // start bit, then v lsb first; line returns to mark afterwards
   task automatic frame(input logic [9:0] v);
      logic [10:0] f;
      f = {v, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clk);
         rxd <= f[i];
         repeat (BIT - 1) @(posedge clk);
      end
      @(posedge clk);
      rxd <= 1'b1;
   endtask : frame
   initial begin
      forever begin
         @(negedge txd);
         repeat (BIT / 2) @(posedge clk);
         if (txd == 1'b0) begin
            for (int i = 0; i < 8; i++) begin
               repeat (BIT) @(posedge clk);
               got[i] = txd;
            end
            got_v <= 1'b1;
            @(posedge clk);
            got_v <= 1'b0;
         end
      end
   end
endmodule : modem_peer

// *** testbench.sv ***
`timescale 1ns/100ps
// *****************
// serial port bench
// *****************
module testbench;
   // a short bit time keeps whole frames within the run's cycle budget
   localparam int BIT = 64;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       wr_s = 1'b0;
   logic       rd_s = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata, got, tb_byte;
   logic       rvalid, busy, done, full, pend, txd, rxd, dsr, cts, dcd;
   logic       dtr, rts, drs, srts, got_v;
   logic [7:0] rd_q[$];
   logic [7:0] tx_q[$];
   int         num_errors = 0;
   int         checks = 0;
   always #2.5 clk = ~clk;
   serial_modem_handshake_error_status #(.BIT_CYCLES(BIT)) dut (.I_CLK_SYS(clk),
      .I_RST_N(rst_n), .i_wr(wr_s), .i_rd(rd_s), .i_addr(addr), .i_wdata(wdata),
      .o_rdata(rdata), .o_rvalid(rvalid),
      .o_tx_busy(busy), .o_tx_done(done), .o_rx_full(full), .o_err_pending(pend),
      .i_rxd(rxd), .i_dsr(dsr), .i_cts(cts), .i_dcd(dcd), .o_txd(txd), .o_dtr(dtr),
      .o_rts(rts), .o_drs(drs), .o_srts(srts));
   modem_peer #(.BIT(BIT)) peer (.clk(clk), .txd(txd), .rxd(rxd), .dsr(dsr), .cts(cts),
      .dcd(dcd), .got(got), .got_v(got_v));
   task automatic fail(input string m);
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
   endtask : fail
   task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e, input string m);
      checks++;
      if (g !== e) fail(m);
   endtask : cmp_byte
   // order: dtr rts drs srts txd pending
   task automatic cmp_pins(input logic [5:0] e, input string m);
      repeat (3) @(posedge clk);
      @(negedge clk);
      checks++;
      if ({dtr, rts, drs, srts, txd, pend} !== e) fail(m);
   endtask : cmp_pins
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : rd
   always @(posedge clk) begin
      if (rvalid === 1'b1) begin
         if (rd_q.size() == 0) fail("unexpected read answer");
         else cmp_byte(rdata, rd_q.pop_front(), "read data");
      end
      if (got_v === 1'b1) begin
         if (tx_q.size() == 0) fail("unexpected serial byte");
         else cmp_byte(got, tx_q.pop_front(), "serial byte");
      end
   end
   task automatic summarize();
      if (rd_q.size() != 0 || tx_q.size() != 0) fail("results missing");
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   task automatic wait_done(input int n);
      int k;
      for (k = 0; k < n && done !== 1'b1; k++) @(negedge clk);
      if (k == n) begin
         fail("transmit timeout");
         summarize();
      end
   endtask : wait_done
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      void'($urandom(92));
      repeat (6) @(posedge clk);
      wr(serial_pkg::MLF_OFFSET, 8'h0C);
      cmp_pins(6'b001110, "force drs srts");
      wr(serial_pkg::MLF_OFFSET, 8'h03);
      cmp_pins(6'b110010, "force dtr rts");
      wr(serial_pkg::RESET_OFFSET, 8'h01);
      cmp_pins(6'b000010, "reset clears force");
      rd(serial_pkg::MLF_OFFSET, 8'h00);
      $display("test force lines finished");
      tb_byte = 8'($urandom);
      tx_q.push_back(tb_byte);
      peer.lines(1'b1, 1'b0, 1'b1);
      wr(serial_pkg::DATA_OFFSET, tb_byte);
      repeat (2000) @(posedge clk);
      cmp_pins(6'b110010, "stalled by cts");
      peer.lines(1'b1, 1'b1, 1'b1);
      wait_done(12 * BIT);
      cmp_pins(6'b000010, "lines dropped after send");
      rd(serial_pkg::RES_OFFSET, 8'h00);
      $display("test transmit finished");
      wr(serial_pkg::CTRL_OFFSET, 8'h01);
      peer.lines(1'b1, 1'b1, 1'b0);
      repeat (4) @(posedge clk);
      cmp_pins(6'b000010, "simple mode carrier lost");
      peer.lines(1'b1, 1'b1, 1'b1);
      repeat (4) @(posedge clk);
      cmp_pins(6'b100010, "simple mode carrier back");
      $display("test simple mode finished");
      wr(serial_pkg::CTRL_OFFSET, 8'h02);
      cmp_pins(6'b100010, "receive lines");
      peer.frame({1'b1, 1'b0, 8'h5A});
      peer.frame({1'b1, 1'b1, 8'h3C});
      repeat (40) @(posedge clk);
      cmp_pins(6'b100011, "error pending");
      rd(serial_pkg::RES_OFFSET, 8'h06);
      cmp_pins(6'b100010, "pending withdrawn");
      rd(serial_pkg::DATA_OFFSET, 8'h5A);
      // even sense from here on, so the all-zero break below has good parity
      wr(serial_pkg::FMT_OFFSET, 8'h1B);
      peer.frame({1'b1, 1'b0, 8'h5A});
      repeat (40) @(posedge clk);
      rd(serial_pkg::RES_OFFSET, 8'h00);
      rd(serial_pkg::DATA_OFFSET, 8'h5A);
      peer.frame(10'h000);
      repeat (40) @(posedge clk);
      rd(serial_pkg::RES_OFFSET, 8'h18);
      rd(serial_pkg::RES_OFFSET, 8'h00);
      wr(serial_pkg::CTRL_OFFSET, 8'h00);
      cmp_pins(6'b000010, "receive end drops dtr");
      $display("test receive finished");
      summarize();
   end
endmodule : testbench
